// >>> hw/dfm_pkg.sv
// Constants shared by the drive fault monitor and position scaling block
`default_nettype none
package dfm_pkg;
    // Fieldbus parameter addresses (16-bit entries)
    localparam logic [15:0] ADDR_COMM_EN   = 16'h050a;
    localparam logic [15:0] ADDR_ERR_CLASS = 16'h0514;
    localparam logic [15:0] ADDR_MAINS_EN  = 16'h051e;
    localparam logic [15:0] ADDR_GND_EN    = 16'h0520;
    localparam logic [15:0] ADDR_STATUS    = 16'h0530;
    localparam logic [15:0] ADDR_DENOM_LO  = 16'h060e;
    localparam logic [15:0] ADDR_DENOM_HI  = 16'h060f;
    localparam logic [15:0] ADDR_NUM_LO    = 16'h0610;
    localparam logic [15:0] ADDR_NUM_HI    = 16'h0611;
    // Reset values
    localparam logic [15:0] RST_ENABLE     = 16'h0001;
    localparam logic [15:0] RST_ERR_CLASS  = 16'h0002;
    localparam logic [31:0] RST_NUM        = 32'h00000001;
    localparam logic [31:0] RST_DENOM      = 32'h00004000;
    // Legal values
    localparam logic [15:0] EN_OFF         = 16'h0000;
    localparam logic [15:0] EN_ON          = 16'h0001;
    localparam logic [15:0] CLASS_MIN      = 16'h0001;
    localparam logic [15:0] CLASS_MAX      = 16'h0003;
    // Status word field positions
    localparam int          ST_GND_BIT     = 0;
    localparam int          ST_PHASE_BIT   = 1;
    localparam int          ST_COMM_BIT    = 2;
    localparam int          ST_3PH_BIT     = 3;
    localparam int          ST_JOG_BIT     = 4;
    // Internal position units per motor revolution, as a shift
    localparam int          INT_REV_SHIFT  = 17;
    // Commutation check: least time of sustained acceleration while braking
    localparam int          CLK_KHZ        = 125000;
    localparam int          COMM_MIN_MS    = 5;
    localparam int          COMM_CYC       = COMM_MIN_MS * CLK_KHZ;
endpackage : dfm_pkg
`default_nettype wire

// >>> hw/dfm_drive_fault_monitor.sv
// Drive supervision parameters, fault monitors and position scaling
// Notes on behaviour
// - Commutation check enable 0/1, default on
// - Check phases for ground fault while enabled
// - Flag phase ground faults, never link/resistor
// - Ground check enable 0/1, default on
// - Three-phase units detect any lost supply phase
// - Phase loss class 1..3, default 2
// - Single-phase units ignore supply phase parameters
// - Supply phase check enable 0/1, default on
// - Convert positions only in jog mode
// - Convert both ways, store user units
// - Ratio is revolutions per user unit
// - Default 16384 user units per revolution
// - Sustained acceleration under braking flags commutation
// - New ratio takes effect on numerator high word write
// - Ratio changes only with amplifier inactive
`timescale 1ns/1ps
`default_nettype none
module dfm_drive_fault_monitor #(
    parameter int COMM_LIMIT = dfm_pkg::COMM_CYC
) (
    input  wire logic                clock_i,         // System clock
    input  wire logic                rst_n_i,         // Synchronous reset, active low
    input  wire logic [15:0]         param_addr_i,    // Parameter address
    input  wire logic                param_wr_i,      // Write strobe
    input  wire logic                param_rd_i,      // Read strobe
    input  wire logic [15:0]         param_wdata_i,   // Write data
    output logic      [15:0]         param_rdata_o,   // Read data
    output logic                     param_ack_o,     // Access done
    output logic                     param_err_o,     // Access refused
    input  wire logic                three_phase_i,   // Variant strap, high = 3-phase
    input  wire logic                amp_enable_i,    // Power amplifier enabled
    input  wire logic                jog_mode_i,      // Jog operating mode active
    input  wire logic [2:0]          gnd_fault_i,     // Per motor phase ground sense pin
    input  wire logic [2:0]          mains_ok_i,      // Per supply phase present pin
    input  wire logic                accel_i,         // Motor accelerating
    input  wire logic                braking_i,       // Regulator braking the motor
    input  wire logic                fault_clear_i,   // Clear latched faults
    input  wire logic signed [31:0]  pos_user_i,      // Position in user units
    input  wire logic signed [31:0]  pos_int_i,       // Position in internal units
    output logic signed [31:0]       pos_int_o,       // Converted to internal units
    output logic signed [31:0]       pos_user_o,      // Converted to user units
    output logic                     gnd_fault_o,     // Ground fault latched
    output logic      [2:0]          gnd_phases_o,    // Phases seen faulty
    output logic                     phase_loss_o,    // Supply phase loss latched
    output logic      [1:0]          phase_class_o,   // Error class for phase loss
    output logic                     comm_fault_o     // Commutation fault latched
);
    import dfm_pkg::*;

    // Refuse a commutation limit the duration counter cannot serve
    if (COMM_LIMIT < 1) begin : g_limit_check
        $error("COMM_LIMIT must be at least one cycle");
    end

    // Parameter registers
    logic [15:0] comm_en_reg, err_class_reg, mains_en_reg, gnd_en_reg;
    logic [31:0] num_reg, denom_reg, denom_pend_reg;
    logic [15:0] num_lo_pend_reg;
    logic [15:0] rdata_reg;
    logic        ack_reg, err_reg;
    // Synchronisers and straps
    logic [2:0]  gnd_s1_reg, gnd_s2_reg, mains_s1_reg, mains_s2_reg;
    logic        ph3_s1_reg, ph3_s2_reg, ph3_reg;
    // Fault state
    logic        gnd_flt_reg, loss_reg, comm_reg;
    logic [2:0]  gnd_ph_reg;
    logic [$clog2(COMM_LIMIT+1)-1:0] comm_cnt_reg;
    logic signed [31:0] pint_reg, puser_reg;

    // Access decode
    wire         hit_comm  = (param_addr_i == ADDR_COMM_EN);
    wire         hit_class = (param_addr_i == ADDR_ERR_CLASS);
    wire         hit_mains = (param_addr_i == ADDR_MAINS_EN);
    wire         hit_gnd   = (param_addr_i == ADDR_GND_EN);
    wire         hit_stat  = (param_addr_i == ADDR_STATUS);
    wire         hit_dlo   = (param_addr_i == ADDR_DENOM_LO);
    wire         hit_dhi   = (param_addr_i == ADDR_DENOM_HI);
    wire         hit_nlo   = (param_addr_i == ADDR_NUM_LO);
    wire         hit_nhi   = (param_addr_i == ADDR_NUM_HI);
    wire         hit_any   = hit_comm | hit_class | hit_mains | hit_gnd | hit_stat |
                             hit_dlo | hit_dhi | hit_nlo | hit_nhi;
    wire         wdat_bool = (param_wdata_i == EN_OFF) || (param_wdata_i == EN_ON);
    wire         wdat_cls  = (param_wdata_i >= CLASS_MIN) && (param_wdata_i <= CLASS_MAX);
    wire [31:0]  num_new   = {param_wdata_i, num_lo_pend_reg};
    // Ratio terms must be 1 .. 2^31-1 and the amplifier must be off
    wire         ratio_ok  = !amp_enable_i && !num_new[31] && (num_new != 32'h0) &&
                             !denom_pend_reg[31] && (denom_pend_reg != 32'h0);
    wire         ratio_wr  = hit_dlo | hit_dhi | hit_nlo;
    wire         wr_ok     = (hit_comm & wdat_bool) | (hit_gnd & wdat_bool) |
                             (hit_mains & wdat_bool) | (hit_class & wdat_cls) |
                             (ratio_wr & !amp_enable_i) | (hit_nhi & ratio_ok);
    wire         wr_take   = param_wr_i & wr_ok;
    wire         commit    = param_wr_i & hit_nhi & ratio_ok;
    wire [15:0]  status_w  = 16'(({15'h0, gnd_flt_reg} << ST_GND_BIT) |
                             ({15'h0, loss_reg} << ST_PHASE_BIT) |
                             ({15'h0, comm_reg} << ST_COMM_BIT) |
                             ({15'h0, ph3_reg} << ST_3PH_BIT) |
                             ({15'h0, jog_mode_i} << ST_JOG_BIT));
    wire [15:0]  rd_mux    = hit_comm  ? comm_en_reg :
                             hit_class ? err_class_reg :
                             hit_mains ? mains_en_reg :
                             hit_gnd   ? gnd_en_reg :
                             hit_stat  ? status_w :
                             hit_dlo   ? denom_reg[15:0] :
                             hit_dhi   ? denom_reg[31:16] :
                             hit_nlo   ? num_reg[15:0] :
                             hit_nhi   ? num_reg[31:16] : 16'h0000;
    wire         rd_err    = param_rd_i & !hit_any;
    wire         wr_err    = param_wr_i & (!wr_ok | hit_stat);

    // Enable and class parameters
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            comm_en_reg   <= RST_ENABLE;
            gnd_en_reg    <= RST_ENABLE;
            mains_en_reg  <= RST_ENABLE;
            err_class_reg <= RST_ERR_CLASS;
        end else if (wr_take) begin
            if (hit_comm)  comm_en_reg   <= param_wdata_i;
            if (hit_gnd)   gnd_en_reg    <= param_wdata_i;
            if (hit_mains) mains_en_reg  <= param_wdata_i;
            if (hit_class) err_class_reg <= param_wdata_i;
        end
    end

    // Scaling ratio: staged halves, active pair replaced on numerator high word
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            num_reg         <= RST_NUM;
            denom_reg       <= RST_DENOM;
            denom_pend_reg  <= RST_DENOM;
            num_lo_pend_reg <= RST_NUM[15:0];
        end else begin
            if (wr_take && hit_dlo) denom_pend_reg[15:0]  <= param_wdata_i;
            if (wr_take && hit_dhi) denom_pend_reg[31:16] <= param_wdata_i;
            if (wr_take && hit_nlo) num_lo_pend_reg       <= param_wdata_i;
            if (commit) begin
                num_reg   <= num_new;
                denom_reg <= denom_pend_reg;
            end
        end
    end

    // Access answer, one cycle after the strobe
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 16'h0000;
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            ack_reg   <= param_rd_i | param_wr_i;
            err_reg   <= rd_err | wr_err;
            if (param_rd_i) rdata_reg <= rd_mux;
        end
    end

    // Pin synchronisers and variant strap capture
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            gnd_s1_reg   <= 3'h0;
            gnd_s2_reg   <= 3'h0;
            mains_s1_reg <= 3'h7;
            mains_s2_reg <= 3'h7;
            ph3_s1_reg   <= 1'b0;
            ph3_s2_reg   <= 1'b0;
        end else begin
            gnd_s1_reg   <= gnd_fault_i;
            gnd_s2_reg   <= gnd_s1_reg;
            mains_s1_reg <= mains_ok_i;
            mains_s2_reg <= mains_s1_reg;
            ph3_s1_reg   <= three_phase_i;
            ph3_s2_reg   <= ph3_s1_reg;
        end
    end

    // Strap not held after release, sampled continuously from the synchroniser
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) ph3_reg <= 1'b0;
        else          ph3_reg <= ph3_s2_reg;
    end

    // Monitor qualification terms
    wire gnd_on    = (gnd_en_reg == EN_ON);
    wire comm_on   = (comm_en_reg == EN_ON);
    wire mains_on  = (mains_en_reg == EN_ON);
    // Only motor phase sense lines are looked at
    wire gnd_set   = amp_enable_i & gnd_on & (gnd_s2_reg != 3'h0);
    wire loss_set  = ph3_reg & mains_on & (mains_s2_reg != 3'h7);
    wire comm_run  = amp_enable_i & comm_on & accel_i & braking_i;
    wire comm_set  = comm_run && (32'(comm_cnt_reg) >= COMM_LIMIT - 1);

    // Latched faults, a new event wins over a clear
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            gnd_flt_reg <= 1'b0;
            gnd_ph_reg  <= 3'h0;
            loss_reg    <= 1'b0;
            comm_reg    <= 1'b0;
        end else begin
            gnd_flt_reg <= gnd_set | (gnd_flt_reg & !fault_clear_i);
            gnd_ph_reg  <= (gnd_set ? gnd_s2_reg : 3'h0) |
                           (fault_clear_i ? 3'h0 : gnd_ph_reg);
            loss_reg    <= loss_set | (loss_reg & !fault_clear_i);
            comm_reg    <= comm_set | (comm_reg & !fault_clear_i);
        end
    end

    // Duration of acceleration against braking
    always_ff @(posedge clock_i) begin
        if (!rst_n_i)      comm_cnt_reg <= '0;
        else if (!comm_run) comm_cnt_reg <= '0;
        else if (!comm_set) comm_cnt_reg <= comm_cnt_reg + 1'b1;
    end

    // Ratio num/denom rev per usr; internal = usr * num * 2^17 / denom
    wire signed [95:0] user_ext  = {{64{pos_user_i[31]}}, pos_user_i};
    wire signed [95:0] int_ext   = {{64{pos_int_i[31]}}, pos_int_i};
    wire signed [95:0] num_ext   = {64'h0, num_reg};
    wire signed [95:0] den_ext   = {64'h0, denom_reg};
    wire signed [95:0] fwd_prod  = (user_ext * num_ext) <<< INT_REV_SHIFT;
    wire signed [95:0] fwd_q     = fwd_prod / den_ext;
    wire signed [95:0] rev_prod  = int_ext * den_ext;
    wire signed [95:0] rev_q     = rev_prod / (num_ext <<< INT_REV_SHIFT);

    // Converted positions refresh only in jog mode, otherwise hold
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pint_reg  <= 32'sh0;
            puser_reg <= 32'sh0;
        end else if (jog_mode_i) begin
            pint_reg  <= fwd_q[31:0];
            puser_reg <= rev_q[31:0];
        end
    end

    // Output drive
    assign param_rdata_o = rdata_reg;
    assign param_ack_o   = ack_reg;
    assign param_err_o   = err_reg;
    assign pos_int_o     = pint_reg;
    assign pos_user_o    = puser_reg;
    assign gnd_fault_o   = gnd_flt_reg;
    assign gnd_phases_o  = gnd_ph_reg;
    assign phase_loss_o  = loss_reg;
    assign phase_class_o = err_class_reg[1:0];
    assign comm_fault_o  = comm_reg;

    // Checks on the parameter and monitor behaviour
    sequence s_reset;
        !rst_n_i;
    endsequence
    sequence s_bad_bool_wr(logic [15:0] a);
        param_wr_i && (param_addr_i == a) && !wdat_bool;
    endsequence

    property p_comm_reset;
        @(posedge clock_i) s_reset |=> (comm_en_reg == RST_ENABLE);
    endproperty
    a_comm_reset: assert property (p_comm_reset) else $error("commutation enable reset");

    property p_gnd_bad;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_bad_bool_wr(ADDR_GND_EN) |=> $stable(gnd_en_reg) && param_err_o && param_ack_o;
    endproperty
    a_gnd_bad: assert property (p_gnd_bad) else $error("bad ground enable taken");

    property p_class_range;
        @(posedge clock_i) disable iff (!rst_n_i)
        (err_class_reg >= CLASS_MIN) && (err_class_reg <= CLASS_MAX);
    endproperty
    a_class_range: assert property (p_class_range) else $error("class out of range");

    property p_mains_bad;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_bad_bool_wr(ADDR_MAINS_EN) |=> $stable(mains_en_reg);
    endproperty
    a_mains_bad: assert property (p_mains_bad) else $error("bad mains enable taken");

    property p_gnd_detect;
        @(posedge clock_i) disable iff (!rst_n_i)
        (amp_enable_i && gnd_on && gnd_s2_reg != 3'h0) |=> gnd_fault_o && gnd_phases_o != 3'h0;
    endproperty
    a_gnd_detect: assert property (p_gnd_detect) else $error("ground fault missed");

    property p_single_phase;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!ph3_reg && !phase_loss_o) |=> !phase_loss_o || fault_clear_i;
    endproperty
    a_single_phase: assert property (p_single_phase) else $error("single phase loss raised");

    property p_ratio_locked;
        @(posedge clock_i) disable iff (!rst_n_i)
        amp_enable_i |=> $stable(num_reg) && $stable(denom_reg);
    endproperty
    a_ratio_locked: assert property (p_ratio_locked) else $error("ratio changed while on");

    property p_denom_only;
        @(posedge clock_i) disable iff (!rst_n_i)
        (param_wr_i && (hit_dlo || hit_dhi)) |=> $stable(denom_reg);
    endproperty
    a_denom_only: assert property (p_denom_only) else $error("denominator took effect");

    property p_comm_off;
        @(posedge clock_i) disable iff (!rst_n_i)
        (!comm_on && !comm_fault_o) |=> !comm_fault_o;
    endproperty
    a_comm_off: assert property (p_comm_off) else $error("disabled check raised fault");

    property p_jog_hold;
        @(posedge clock_i) disable iff (!rst_n_i)
        !jog_mode_i |=> $stable(pos_int_o) && $stable(pos_user_o);
    endproperty
    a_jog_hold: assert property (p_jog_hold) else $error("conversion outside jog");
endmodule : dfm_drive_fault_monitor
`default_nettype wire

// >>> tb/dfm_drive_fault_monitor_tb.sv
// Self-checking testbench for the drive fault monitor and position scaling block
`timescale 1ns/1ps
`default_nettype none
module dfm_drive_fault_monitor_tb;
    import dfm_pkg::*;
    logic               clock_i, rst_n_i, param_wr_i, param_rd_i, param_ack_o, param_err_o;
    logic        [15:0] param_addr_i, param_wdata_i, param_rdata_o;
    logic               three_phase_i, amp_enable_i, jog_mode_i, accel_i, braking_i;
    logic        [2:0]  gnd_fault_i, mains_ok_i, gnd_phases_o;
    logic               fault_clear_i, gnd_fault_o, phase_loss_o, comm_fault_o;
    logic signed [31:0] pos_user_i, pos_int_i, pos_int_o, pos_user_o;
    logic        [1:0]  phase_class_o;
    wire         [2:0]  flags = {comm_fault_o, phase_loss_o, gnd_fault_o};
    int                 errors, n_tests, k;
    logic        [15:0] en_addr [3] = '{ADDR_COMM_EN, ADDR_MAINS_EN, ADDR_GND_EN};

    dfm_drive_fault_monitor #(.COMM_LIMIT(8)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .param_addr_i(param_addr_i),
        .param_wr_i(param_wr_i), .param_rd_i(param_rd_i), .param_wdata_i(param_wdata_i),
        .param_rdata_o(param_rdata_o), .param_ack_o(param_ack_o), .param_err_o(param_err_o),
        .three_phase_i(three_phase_i), .amp_enable_i(amp_enable_i), .jog_mode_i(jog_mode_i),
        .gnd_fault_i(gnd_fault_i), .mains_ok_i(mains_ok_i), .accel_i(accel_i),
        .braking_i(braking_i), .fault_clear_i(fault_clear_i), .pos_user_i(pos_user_i),
        .pos_int_i(pos_int_i), .pos_int_o(pos_int_o), .pos_user_o(pos_user_o),
        .gnd_fault_o(gnd_fault_o), .gnd_phases_o(gnd_phases_o), .phase_loss_o(phase_loss_o),
        .phase_class_o(phase_class_o), .comm_fault_o(comm_fault_o)
    );

    // Free-running system clock
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // Verdict and end of run
    task automatic end_of_test();
        if (errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    // One comparison, counted
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Wait n edges, then settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc

    // One parameter access: one-cycle strobe, ack and err one cycle later
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                       input logic e);
        cyc(1);
        param_wr_i    = w;
        param_rd_i    = ~w;
        param_addr_i  = a;
        param_wdata_i = d;
        cyc(1);
        param_wr_i = 1'b0;
        param_rd_i = 1'b0;
        chk("ack", 32'h1, {31'h0, param_ack_o});
        chk("err", {31'h0, e}, {31'h0, param_err_o});
    endtask : acc

    // Parameter read with expected data
    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic e);
        acc(1'b0, a, 16'h0000, e);
        chk("rdata", {16'h0, exp}, {16'h0, param_rdata_o});
    endtask : rd

    // Bounded wait for a fault flag; a missing flag ends the run
    task automatic flag(input int f, input logic exp, input string nm);
        int i;
        for (i = 0; i < 12 && flags[f] !== 1'b1; i++) begin
            cyc(1);
        end
        chk(nm, {31'h0, exp}, {31'h0, flags[f]});
        if (exp && flags[f] !== 1'b1) begin
            end_of_test();
        end
    endtask : flag

    // Drop fault causes, let synchronisers drain, clear latches
    task automatic clear_all();
        amp_enable_i = 1'b0; accel_i = 1'b0; braking_i = 1'b0;
        gnd_fault_i = 3'h0; mains_ok_i = 3'h7;
        cyc(5);
        fault_clear_i = 1'b1;
        cyc(1);
        fault_clear_i = 1'b0;
        cyc(1);
        chk("flags", 32'h0, {29'h0, flags});
    endtask : clear_all

    // Main sequence
    initial begin
        errors = 0; n_tests = 0;
        rst_n_i = 1'b0; param_wr_i = 1'b0; param_rd_i = 1'b0;
        param_addr_i = 16'h0000; param_wdata_i = 16'h0000;
        three_phase_i = 1'b1; amp_enable_i = 1'b0; jog_mode_i = 1'b0;
        gnd_fault_i = 3'h0; mains_ok_i = 3'h7; accel_i = 1'b0; braking_i = 1'b0;
        fault_clear_i = 1'b0; pos_user_i = 32'sh0; pos_int_i = 32'sh0;
        cyc(5);
        chk("class", 32'h2, {30'h0, phase_class_o});
        rst_n_i = 1'b1;
        cyc(4);
        // Enables: default on, only 0 and 1 taken
        for (k = 0; k < 3; k++) begin
            rd(en_addr[k], EN_ON, 1'b0);
            acc(1'b1, en_addr[k], 16'h0002, 1'b1);
            rd(en_addr[k], EN_ON, 1'b0);
            acc(1'b1, en_addr[k], EN_OFF, 1'b0);
            rd(en_addr[k], EN_OFF, 1'b0);
            acc(1'b1, en_addr[k], EN_ON, 1'b0);
        end
        // Error class: 1..3 only, default 2
        rd(ADDR_ERR_CLASS, 16'h0002, 1'b0);
        acc(1'b1, ADDR_ERR_CLASS, 16'h0000, 1'b1);
        acc(1'b1, ADDR_ERR_CLASS, 16'h0004, 1'b1);
        for (k = 1; k < 4; k++) begin
            acc(1'b1, ADDR_ERR_CLASS, 16'(k), 1'b0);
            chk("class", k, {30'h0, phase_class_o});
        end
        acc(1'b1, ADDR_ERR_CLASS, 16'h0002, 1'b0);
        rd(16'h0600, 16'h0000, 1'b1);
        acc(1'b1, ADDR_STATUS, 16'h0001, 1'b1);
        // Ground fault on two phases while amplifier is on
        amp_enable_i = 1'b1; gnd_fault_i = 3'b101;
        flag(0, 1'b1, "gnd_fault");
        chk("gnd_phases", 32'h5, {29'h0, gnd_phases_o});
        rd(ADDR_STATUS, 16'h0009, 1'b0);
        clear_all();
        gnd_fault_i = 3'b001;
        flag(0, 1'b0, "gnd_amp_off");
        acc(1'b1, ADDR_GND_EN, EN_OFF, 1'b0);
        amp_enable_i = 1'b1;
        flag(0, 1'b0, "gnd_disabled");
        clear_all();
        acc(1'b1, ADDR_GND_EN, EN_ON, 1'b0);
        // Supply phase loss
        mains_ok_i = 3'b011;
        flag(1, 1'b1, "phase_loss");
        rd(ADDR_STATUS, 16'h000a, 1'b0);
        clear_all();
        acc(1'b1, ADDR_MAINS_EN, EN_OFF, 1'b0);
        mains_ok_i = 3'b101;
        flag(1, 1'b0, "loss_disabled");
        clear_all();
        three_phase_i = 1'b0;
        acc(1'b1, ADDR_MAINS_EN, EN_ON, 1'b0);
        cyc(6);
        mains_ok_i = 3'b110;
        flag(1, 1'b0, "loss_single");
        clear_all();
        three_phase_i = 1'b1;
        cyc(6);
        // Commutation: seven cycles too short, then sustained
        amp_enable_i = 1'b1; accel_i = 1'b1; braking_i = 1'b1;
        cyc(7);
        accel_i = 1'b0;
        flag(2, 1'b0, "comm_short");
        accel_i = 1'b1;
        flag(2, 1'b1, "comm_fault");
        rd(ADDR_STATUS, 16'h000c, 1'b0);
        clear_all();
        acc(1'b1, ADDR_COMM_EN, EN_OFF, 1'b0);
        amp_enable_i = 1'b1; accel_i = 1'b1; braking_i = 1'b1;
        flag(2, 1'b0, "comm_disabled");
        clear_all();
        // Default scaling, both directions, only in jog mode
        pos_user_i = 32'sh4000; pos_int_i = 32'sh20000;
        cyc(3);
        chk("int_nojog", 32'h0, pos_int_o);
        jog_mode_i = 1'b1;
        cyc(2);
        chk("int_dflt", 32'h20000, pos_int_o);
        chk("user_dflt", 32'h4000, pos_user_o);
        rd(ADDR_STATUS, 16'h0018, 1'b0);
        // Ratio changes: refused with amplifier on, taken on numerator
        amp_enable_i = 1'b1;
        acc(1'b1, ADDR_DENOM_LO, 16'h0457, 1'b1);
        amp_enable_i = 1'b0;
        acc(1'b1, ADDR_DENOM_LO, 16'h0457, 1'b0);
        acc(1'b1, ADDR_DENOM_HI, 16'h0000, 1'b0);
        rd(ADDR_DENOM_LO, 16'h4000, 1'b0);
        chk("int_pend", 32'h20000, pos_int_o);
        acc(1'b1, ADDR_NUM_LO, 16'h0000, 1'b0);
        acc(1'b1, ADDR_NUM_HI, 16'h0000, 1'b1);
        acc(1'b1, ADDR_NUM_LO, 16'h0003, 1'b0);
        acc(1'b1, ADDR_NUM_HI, 16'h0000, 1'b0);
        rd(ADDR_DENOM_LO, 16'h0457, 1'b0);
        pos_user_i = 32'sd900;
        cyc(2);
        chk("int_ratio", 32'((64'd900 * 3 * 131072) / 1111), pos_int_o);
        chk("user_ratio", 32'(1111 / 3), pos_user_o);
        jog_mode_i = 1'b0;
        pos_user_i = 32'sd5;
        cyc(3);
        chk("int_hold", 32'((64'd900 * 3 * 131072) / 1111), pos_int_o);
        // Mid-run reset restores defaults of the changed parameters
        rst_n_i = 1'b0;
        cyc(5);
        rst_n_i = 1'b1;
        cyc(4);
        rd(ADDR_COMM_EN, EN_ON, 1'b0);
        rd(ADDR_DENOM_LO, 16'h4000, 1'b0);
        rd(ADDR_NUM_LO, 16'h0001, 1'b0);
        chk("pos_rst", 32'h0, pos_int_o);
        end_of_test();
    end
endmodule : dfm_drive_fault_monitor_tb
`default_nettype wire
